// ---- inc/eeprom_config_preloader_defines.vh ----
// constants shared by the configuration preloader and its serial engines
`ifndef EEPROM_CONFIG_PRELOADER_DEFINES_VH
`define EEPROM_CONFIG_PRELOADER_DEFINES_VH

// =====
// preload image layout (eeprom word addresses)
`define PRELOAD_WORDS      21
`define W_COUNT            5'h00
`define W_FLAG             5'h01
`define W_HS_DEV           5'h02
`define W_HS_CFG           5'h03
`define W_MAC0             5'h04
`define W_LANG             5'h07
`define W_STR0             5'h08
`define W_PHY_OFS          5'h0F
`define W_MAX_FRAME        5'h10
`define W_PHY_MGMT_ID           5'h11
`define W_WATER            5'h12
`define W_FS_DEV           5'h13
`define W_FS_CFG           5'h14

// =====
// flag word bit positions
`define F_SELF_PWR         0
`define F_REMOTE_WAKE      2
`define F_CHIRP_K_DIS      4
`define F_SW_PHY_RST       5
`define F_RX_CRC_STRIP     6
`define F_TX_CRC_APPEND    7
`define F_CAPTURE_EFF      12
`define F_DEBUG_PORT       13

// =====
// phy_mgmt_id byte and type codes
`define PHY_TYPE_MSB       7
`define PHY_TYPE_LSB       5
`define PHY_ADDR_MSB       4
`define PHY_TYPE_NORMAL    3'h0
`define PHY_TYPE_GIGABIT   3'h1
`define PHY_TYPE_FORCED    3'h4
`define PHY_TYPE_ABSENT    3'h7

// =====
// frame size limits and power-down write
`define MAX_FRAME_LIMIT    16'h09C4
`define JUMBO_FRAME_SIZE   16'h2400
`define PD_BROADCAST_ID    5'h00
`define PD_REG_ADDR        5'h00
`define PD_REG_DATA        16'h0800

// =====
// serial frame headers
`define EE_READ_HDR        3'h6
`define MDIO_PREAMBLE      32'hFFFFFFFF
`define MDIO_ST_WR         4'h5
`define MDIO_TA            2'h2

`endif

// ---- hdl/eeprom_microwire_reader.v ----
// three-wire serial eeprom single word reader
`timescale 1ns/10ps
`include "eeprom_config_preloader_defines.vh"
module eeprom_microwire_reader #(
   parameter AW  = 8,                // eeprom word address width
   parameter DIV = 4                 // system clocks per serial half bit
) (
   // system
   input  wire          clk_sys,
   input  wire          nrst,
   // request and answer
   input  wire          start,
   input  wire [AW-1:0] addr,
   output reg           done,
   output reg  [15:0]   data,
   // eeprom pins
   output reg           ee_cs,
   output reg           ee_sk,
   output reg           ee_di,
   input  wire          ee_do
);
   localparam N = 3 + AW + 17;       // start+opcode, address, dummy+16 data

   reg [N-1:0] sh_reg;               // command out at top, data in at bottom
   reg [7:0]   cnt_reg;              // serial clocks left
   reg [7:0]   div_reg;              // half bit divider
   reg         busy_reg;             // frame in progress

   // =====
   // shift engine: di changes and do is sampled on the falling sk edge
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sh_reg   <= {N{1'b0}};
         cnt_reg  <= 8'h00;
         div_reg  <= 8'h00;
         busy_reg <= 1'b0;
         done     <= 1'b0;
         data     <= 16'h0000;
         ee_cs    <= 1'b0;
         ee_sk    <= 1'b0;
         ee_di    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!busy_reg) begin
            if (start) begin
               // standard read command from the given word address
               sh_reg   <= {`EE_READ_HDR, addr, 17'h00000};
               cnt_reg  <= N[7:0];
               div_reg  <= 8'h00;
               busy_reg <= 1'b1;
               ee_cs    <= 1'b1;
               ee_di    <= 1'b1;
            end
         end else if (div_reg != DIV[7:0] - 8'h01) begin
            div_reg <= div_reg + 8'h01;
         end else begin
            div_reg <= 8'h00;
            if (!ee_sk) begin
               // rising edge: eeprom samples di
               ee_sk <= 1'b1;
            end else begin
               // falling edge: take do, present next command bit
               ee_sk   <= 1'b0;
               sh_reg  <= {sh_reg[N-2:0], ee_do};
               ee_di   <= sh_reg[N-2];
               cnt_reg <= cnt_reg - 8'h01;
               if (cnt_reg == 8'h01) begin
                  busy_reg <= 1'b0;
                  ee_cs    <= 1'b0;
                  ee_di    <= 1'b0;
                  done     <= 1'b1;
                  data     <= {sh_reg[14:0], ee_do};
               end
            end
         end
      end
   end
endmodule

// ---- hdl/mdio_frame_writer.v ----
// station management write frame generator
`timescale 1ns/10ps
`include "eeprom_config_preloader_defines.vh"
module mdio_frame_writer #(
   parameter DIV = 4                 // system clocks per mdc half period
) (
   // system
   input  wire        clk_sys,
   input  wire        nrst,
   // request and answer
   input  wire        start,
   input  wire [4:0]  phy_mgmt_id,
   input  wire [4:0]  reg_addr,
   input  wire [15:0] wr_data,
   output reg         done,
   // management pins
   output reg         mdc,
   output reg         mdio_o,
   output reg         mdio_oe
);
   reg [63:0] sh_reg;                // whole frame, msb first
   reg [6:0]  cnt_reg;               // bits left
   reg [7:0]  div_reg;               // half period divider
   reg        busy_reg;              // frame in progress

   // =====
   // frame shifter: data changes on falling mdc, phy samples on rising
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sh_reg   <= 64'h0;
         cnt_reg  <= 7'h00;
         div_reg  <= 8'h00;
         busy_reg <= 1'b0;
         done     <= 1'b0;
         mdc      <= 1'b0;
         mdio_o   <= 1'b0;
         mdio_oe  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!busy_reg) begin
            if (start) begin
               // five bit phy_mgmt_id shares the bus among several phys
               sh_reg   <= {`MDIO_PREAMBLE, `MDIO_ST_WR, phy_mgmt_id, reg_addr,
                            `MDIO_TA, wr_data};
               cnt_reg  <= 7'h40;
               div_reg  <= 8'h00;
               busy_reg <= 1'b1;
               mdio_o   <= 1'b1;
               mdio_oe  <= 1'b1;
            end
         end else if (div_reg != DIV[7:0] - 8'h01) begin
            div_reg <= div_reg + 8'h01;
         end else begin
            div_reg <= 8'h00;
            if (!mdc) begin
               mdc <= 1'b1;
            end else begin
               mdc     <= 1'b0;
               sh_reg  <= {sh_reg[62:0], 1'b0};
               mdio_o  <= sh_reg[62];
               cnt_reg <= cnt_reg - 7'h01;
               if (cnt_reg == 7'h01) begin
                  // release the line once the last data bit is sampled
                  busy_reg <= 1'b0;
                  mdio_oe  <= 1'b0;
                  mdio_o   <= 1'b0;
                  done     <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// ---- hdl/eeprom_config_preloader.v ----
// power-on configuration preloader: eeprom fetch, decode, phy power-down
//
// Notes on behaviour
// - fetch starts alone after power-on reset
// - twenty-one words, addresses zero upward
// - words 02h/03h: high-speed descriptor offset, length
// - words 13h/14h: full-speed descriptor offset, length
// - words 04h-06h: mac address, low byte first
// - word 07h language id; 08h-0Eh string pointers
// - flag bit 0 reports self powered
// - flag bit 2 advertises remote wakeup
// - flag bit 4 suppresses chirp k
// - flag bit 5 selects phy reset source
// - flag bit 6 strips received crc
// - flag bit 7 appends transmit crc
// - bits 12/13: capture effect, debug port
// - first 0Fh field names phy status register
// - second 0Fh field names another phy register
// - max frame from 10h, jumbo forces 9216
// - word 11h: type and id per phy
// - decode type codes 000,100,001,111
// - pause between high and low water marks
// - one water mark unit is 256 bytes
// - three power-down writes: broadcast, primary, secondary
// - management writes carry five bit phy_mgmt_id
`timescale 1ns/10ps
`include "eeprom_config_preloader_defines.vh"
module eeprom_config_preloader #(
   parameter EE_AW    = 8,           // eeprom word address width
   parameter SER_DIV  = 4,           // clocks per serial half bit
   parameter NWORDS   = `PRELOAD_WORDS
) (
   // system
   input  wire         clk_sys,
   input  wire         nrst,
   // serial eeprom
   output reg          ee_cs,
   output reg          ee_sk,
   output reg          ee_di,
   input  wire         ee_do,
   // station management
   output reg          mdc,
   output reg          mdio_o,
   output reg          mdio_oe,
   // load status
   output reg          config_valid,
   output reg  [7:0]   preload_count,
   // usb descriptor pointers: slot 0 hs dev, 1 hs cfg, 2 fs dev,
   // 3 fs cfg, 4..10 strings
   output reg  [87:0]  desc_offset,
   output reg  [87:0]  desc_length,
   output reg  [15:0]  lang_id,
   // station address, byte 0 in bits 7:0
   output reg  [47:0]  mac_addr,
   // flag decode
   output reg          self_powered_flag,
   output reg          remote_wake_capable,
   output reg          chirp_k_disable,
   output reg          sw_phy_reset_select,
   output reg          rx_crc_strip_enable,
   output reg          tx_crc_append_enable,
   output reg          capture_effect_enable,
   output reg          debug_port_enable,
   // interrupt endpoint phy register selects
   output reg  [4:0]   intr_phy_reg_a,
   output reg  [4:0]   intr_phy_reg_b,
   // frame size
   input  wire         jumbo_mode,
   output reg  [15:0]  max_frame_size,
   // phy identity, index 0 primary, 1 secondary
   output reg  [9:0]   phy_mgmt_id,
   output reg  [1:0]   phy_present,
   output reg  [1:0]   phy_gigabit,
   output reg  [1:0]   phy_link_forced,
   // flow control
   input  wire         full_duplex,
   input  wire [7:0]   rx_free_blocks,
   output reg          pause_active,
   // phy reset
   input  wire         phy_reset_level,
   input  wire         phy_reset_enable_bit,
   input  wire         usb_bus_reset,
   output reg          phy_reset_out_n
);
   // =====
   // states
   localparam S_RD_ISSUE = 3'h0;     // start one eeprom read
   localparam S_RD_WAIT  = 3'h1;     // wait for the word
   localparam S_DECODE   = 3'h2;     // latch decoded fields
   localparam S_PD_ISSUE = 3'h3;     // start one power-down write
   localparam S_PD_WAIT  = 3'h4;     // wait for the frame
   localparam S_DONE     = 3'h5;     // configuration in force

   reg [2:0]  state_reg;             // controller state
   reg [4:0]  idx_reg;               // word index being read
   reg [1:0]  pd_reg;                // power-down write number
   reg [15:0] word_mem [0:NWORDS-1]; // raw preload image
   reg        rd_start;              // read request pulse
   reg        wr_start;              // write request pulse
   reg [4:0]  wr_id;                 // phy_mgmt_id for current write
   reg [15:0] max_next;              // clamped frame size
   reg        loaded_reg;            // fields latched

   wire        rd_done;              // word arrived
   wire [15:0] rd_data;              // word value
   wire        wr_done;              // management frame finished
   wire        sk_w;
   wire        cs_w;
   wire        di_w;
   wire        mdc_w;
   wire        mo_w;
   wire        moe_w;
   wire [15:0] flag_w;
   wire [15:0] ids_w;

   assign flag_w = word_mem[`W_FLAG];
   assign ids_w  = word_mem[`W_PHY_MGMT_ID];

   // =====
   // serial engines
   eeprom_microwire_reader #(.AW(EE_AW), .DIV(SER_DIV)) u_reader (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .start   (rd_start),
      .addr    ({{(EE_AW-5){1'b0}}, idx_reg}),
      .done    (rd_done),
      .data    (rd_data),
      .ee_cs   (cs_w),
      .ee_sk   (sk_w),
      .ee_di   (di_w),
      .ee_do   (ee_do)
   );

   mdio_frame_writer #(.DIV(SER_DIV)) u_writer (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .start       (wr_start),
      .phy_mgmt_id (wr_id),
      .reg_addr    (`PD_REG_ADDR),
      .wr_data     (`PD_REG_DATA),
      .done        (wr_done),
      .mdc         (mdc_w),
      .mdio_o      (mo_w),
      .mdio_oe     (moe_w)
   );

   // =====
   // power-down target: broadcast first, then primary, then secondary
   always @* begin
      case (pd_reg)
         2'h0:    wr_id = `PD_BROADCAST_ID;
         2'h1:    wr_id = ids_w[`PHY_ADDR_MSB:0];
         default: wr_id = ids_w[8+`PHY_ADDR_MSB:8];
      endcase
   end

   // frame size: jumbo overrides, otherwise even and capped
   always @* begin
      if (jumbo_mode)
         max_next = `JUMBO_FRAME_SIZE;
      else if (word_mem[`W_MAX_FRAME] > `MAX_FRAME_LIMIT)
         max_next = `MAX_FRAME_LIMIT;
      else
         max_next = {word_mem[`W_MAX_FRAME][15:1], 1'b0};
   end

   // =====
   // load sequencer; runs once, no host request needed
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg  <= S_RD_ISSUE;
         idx_reg    <= 5'h00;
         pd_reg     <= 2'h0;
         rd_start   <= 1'b0;
         wr_start   <= 1'b0;
         loaded_reg <= 1'b0;
      end else begin
         rd_start <= 1'b0;
         wr_start <= 1'b0;
         case (state_reg)
            S_RD_ISSUE: begin
               rd_start  <= 1'b1;
               state_reg <= S_RD_WAIT;
            end
            S_RD_WAIT: begin
               if (rd_done) begin
                  // fixed image length; the count word is only reported
                  if (idx_reg == NWORDS[4:0] - 5'h01) begin
                     state_reg <= S_DECODE;
                  end else begin
                     idx_reg   <= idx_reg + 5'h01;
                     state_reg <= S_RD_ISSUE;
                  end
               end
            end
            S_DECODE: begin
               loaded_reg <= 1'b1;
               state_reg  <= S_PD_ISSUE;
            end
            S_PD_ISSUE: begin
               wr_start  <= 1'b1;
               state_reg <= S_PD_WAIT;
            end
            S_PD_WAIT: begin
               if (wr_done) begin
                  if (pd_reg == 2'h2) begin
                     state_reg <= S_DONE;
                  end else begin
                     pd_reg    <= pd_reg + 2'h1;
                     state_reg <= S_PD_ISSUE;
                  end
               end
            end
            S_DONE: begin
               state_reg <= S_DONE;
            end
            default: begin
               state_reg <= S_RD_ISSUE;
            end
         endcase
      end
   end

   // raw image store; no reset needed, nothing reads it before load
   always @(posedge clk_sys) begin
      if (state_reg == S_RD_WAIT && rd_done)
         word_mem[idx_reg] <= rd_data;
   end

   // =====
   // descriptor pointers, one slot per loop pass
   genvar g;
   generate
      for (g = 0; g < 11; g = g + 1) begin : g_desc
         localparam integer WI = (g < 2) ? (`W_HS_DEV + g) :
                               (g < 4) ? (`W_FS_DEV + g - 2) :
                                         (`W_STR0 + g - 4);
         always @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               desc_offset[g*8 +: 8] <= 8'h00;
               desc_length[g*8 +: 8] <= 8'h00;
            end else if (state_reg == S_DECODE) begin
               // offset low byte, length high byte
               desc_offset[g*8 +: 8] <= word_mem[WI][7:0];
               desc_length[g*8 +: 8] <= word_mem[WI][15:8];
            end
         end
      end
      // per phy identity and type decode
      for (g = 0; g < 2; g = g + 1) begin : g_phy
         always @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               phy_mgmt_id[g*5 +: 5] <= 5'h00;
               phy_present[g]        <= 1'b0;
               phy_gigabit[g]        <= 1'b0;
               phy_link_forced[g]    <= 1'b0;
            end else if (state_reg == S_DECODE) begin
               phy_mgmt_id[g*5 +: 5] <= ids_w[g*8 +: 5];
               phy_present[g]     <= ids_w[g*8+5 +: 3] != `PHY_TYPE_ABSENT;
               phy_gigabit[g]     <= ids_w[g*8+5 +: 3] == `PHY_TYPE_GIGABIT;
               phy_link_forced[g] <= ids_w[g*8+5 +: 3] == `PHY_TYPE_FORCED;
            end
         end
      end
   endgenerate

   // =====
   // remaining decoded fields, latched once the image is complete
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         preload_count         <= 8'h00;
         lang_id               <= 16'h0000;
         mac_addr              <= 48'h0;
         self_powered_flag     <= 1'b0;
         remote_wake_capable   <= 1'b0;
         chirp_k_disable       <= 1'b0;
         sw_phy_reset_select   <= 1'b0;
         rx_crc_strip_enable   <= 1'b0;
         tx_crc_append_enable  <= 1'b0;
         capture_effect_enable <= 1'b0;
         debug_port_enable     <= 1'b0;
         intr_phy_reg_a        <= 5'h00;
         intr_phy_reg_b        <= 5'h00;
      end else if (state_reg == S_DECODE) begin
         preload_count <= word_mem[`W_COUNT][7:0];
         lang_id       <= word_mem[`W_LANG];
         // byte 0 is the first octet on the wire
         mac_addr <= {word_mem[`W_MAC0+2], word_mem[`W_MAC0+1],
                      word_mem[`W_MAC0]};
         self_powered_flag     <= flag_w[`F_SELF_PWR];
         remote_wake_capable   <= flag_w[`F_REMOTE_WAKE];
         chirp_k_disable       <= flag_w[`F_CHIRP_K_DIS];
         sw_phy_reset_select   <= flag_w[`F_SW_PHY_RST];
         rx_crc_strip_enable   <= flag_w[`F_RX_CRC_STRIP];
         tx_crc_append_enable  <= flag_w[`F_TX_CRC_APPEND];
         capture_effect_enable <= flag_w[`F_CAPTURE_EFF];
         debug_port_enable     <= flag_w[`F_DEBUG_PORT];
         intr_phy_reg_a <= word_mem[`W_PHY_OFS][12:8];
         intr_phy_reg_b <= word_mem[`W_PHY_OFS][4:0];
      end
   end

   // =====
   // live outputs: pins, frame size, pause hysteresis, phy reset
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ee_cs           <= 1'b0;
         ee_sk           <= 1'b0;
         ee_di           <= 1'b0;
         mdc             <= 1'b0;
         mdio_o          <= 1'b0;
         mdio_oe         <= 1'b0;
         config_valid    <= 1'b0;
         max_frame_size  <= 16'h0000;
         pause_active    <= 1'b0;
         phy_reset_out_n <= 1'b0;
      end else begin
         // one flop stage keeps every top output registered
         ee_cs   <= cs_w;
         ee_sk   <= sk_w;
         ee_di   <= di_w;
         mdc     <= mdc_w;
         mdio_o  <= mo_w;
         mdio_oe <= moe_w;
         // usb and flow control stay off until sequence ends; mac frame size stays zero until fields latch
         config_valid   <= (state_reg == S_DONE);
         max_frame_size <= loaded_reg ? max_next : 16'h0000;
         // water marks count 256 byte blocks of free rx storage
         if (!full_duplex || state_reg != S_DONE)
            pause_active <= 1'b0;
         else if (rx_free_blocks <= word_mem[`W_WATER][15:8])
            pause_active <= 1'b1;
         else if (rx_free_blocks >= word_mem[`W_WATER][7:0])
            pause_active <= 1'b0;
         // reset held asserted while loading
         if (!loaded_reg)
            phy_reset_out_n <= 1'b0;
         else if (sw_phy_reset_select)
            phy_reset_out_n <= phy_reset_enable_bit ? phy_reset_level : 1'b1;
         else
            phy_reset_out_n <= ~(phy_reset_enable_bit & usb_bus_reset);
      end
   end
endmodule

// ---- dv/eeprom_serial_model.sv ----
// behavioural three-wire serial eeprom answering word reads
`timescale 1ns/10ps
module eeprom_serial_model (
   // pins
   input  wire logic ee_cs,
   input  wire logic ee_sk,
   input  wire logic ee_di,
   output wire logic ee_do
);
   logic [15:0] mem [0:255];  // word image, filled by the bench
   logic [10:0] hdr;          // opcode and address
   logic        d = 1'b0;     // bit on the pin
   int          n = 0;        // rising edges in this frame
   int          addrs[$];     // addresses in request order
   int          bad_hdr = 0;  // frames that were not reads
   // deselected: inverse of the last bit, so a stale sample shows up
   assign ee_do = (ee_cs && n >= 12) ? d : ~d;
   always @(negedge ee_cs) n = 0;
   // =====
   // shift header in, word out msb first after a dummy zero
   always @(posedge ee_sk) if (ee_cs) begin
      n = n + 1;
      if (n <= 11) hdr = {hdr[9:0], ee_di};
      if (n == 11) begin
         if (hdr[10:8] !== 3'h6) bad_hdr++;
         addrs.push_back(int'(hdr[7:0]));
      end
      #2 if (n >= 12 && n <= 28) d = (n == 12) ? 1'b0 : mem[hdr[7:0]][28-n];
   end
endmodule

// ---- dv/eeprom_config_preloader_properties.sv ----
// port assertions for the configuration preloader
`timescale 1ns/10ps
module eeprom_config_preloader_properties (
   // system
   input logic        clk_sys,
   input logic        nrst,
   // serial pins
   input logic        ee_cs,
   input logic        ee_sk,
   input logic        ee_di,
   input logic        mdio_o,
   input logic        mdio_oe,
   // decoded state and live inputs
   input logic        config_valid,
   input logic        jumbo_mode,
   input logic [15:0] max_frame_size,
   input logic        full_duplex,
   input logic        pause_active,
   input logic        sw_phy_reset_select,
   input logic        phy_reset_level,
   input logic        phy_reset_enable_bit,
   input logic        usb_bus_reset,
   input logic        phy_reset_out_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // frames keep select or enable up well past eight clocks
   sequence s_cs_held; ee_cs [*8]; endsequence
   sequence s_oe_held; mdio_oe [*8]; endsequence
   // loaded on this edge and the one before
   sequence s_live; config_valid && $past(config_valid); endsequence
   property p_frame_jumbo; s_live ##0 $past(jumbo_mode) |-> max_frame_size == 16'h2400; endproperty
   property p_frame_std;
      s_live ##0 !$past(jumbo_mode) |-> max_frame_size <= 16'h09C4 && !max_frame_size[0];
   endproperty
   property p_pause_off; $past(config_valid) && !$past(full_duplex) |-> !pause_active; endproperty
   property p_rst_sw;
      s_live ##0 $past(sw_phy_reset_select && phy_reset_enable_bit)
         |-> phy_reset_out_n == $past(phy_reset_level);
   endproperty
   property p_rst_usb;
      s_live ##0 !$past(sw_phy_reset_select)
         |-> phy_reset_out_n == !$past(phy_reset_enable_bit && usb_bus_reset);
   endproperty
   property p_load_hold; ee_cs |-> !mdio_oe && !config_valid && !phy_reset_out_n; endproperty
   property p_done_quiet; config_valid |=> config_valid && !ee_cs && !mdio_oe; endproperty
   property p_ee_frame; $rose(ee_cs) |-> ee_di && !ee_sk ##1 s_cs_held; endproperty
   property p_pd_frame; $rose(mdio_oe) |-> mdio_o ##1 s_oe_held; endproperty
   a_frame_jumbo: assert property (p_frame_jumbo) else $error("jumbo size wrong");
   a_frame_std: assert property (p_frame_std) else $error("frame size bad");
   a_pause_off: assert property (p_pause_off) else $error("pause in half duplex");
   a_rst_sw: assert property (p_rst_sw) else $error("sw phy reset wrong");
   a_rst_usb: assert property (p_rst_usb) else $error("usb phy reset wrong");
   a_load_hold: assert property (p_load_hold) else $error("early dependent");
   a_done_quiet: assert property (p_done_quiet) else $error("traffic after load");
   a_ee_frame: assert property (p_ee_frame) else $error("eeprom frame short");
   a_pd_frame: assert property (p_pd_frame) else $error("mdio frame short");
endmodule
bind eeprom_config_preloader eeprom_config_preloader_properties u_props (.*);

// ---- dv/eeprom_config_preloader_tb_top.sv ----
// self-checking bench for the configuration preloader
`timescale 1ns/10ps
`include "eeprom_config_preloader_defines.vh"
module eeprom_config_preloader_tb_top;
   logic        clk_sys, nrst, jumbo_mode, full_duplex, phy_reset_level;
   logic        phy_reset_enable_bit, usb_bus_reset, pm, pr;
   logic [7:0]  rx_free_blocks, preload_count;
   logic        ee_cs, ee_sk, ee_di, ee_do, mdc, mdio_o, mdio_oe, config_valid, pause_active;
   logic        self_powered_flag, remote_wake_capable, chirp_k_disable, sw_phy_reset_select;
   logic        rx_crc_strip_enable, tx_crc_append_enable, capture_effect_enable;
   logic        debug_port_enable, phy_reset_out_n;
   logic [87:0] desc_offset, desc_length;
   logic [47:0] mac_addr;
   logic [15:0] lang_id, max_frame_size, fsx, fs [4] = '{16'h0BB8, 16'h05EF, 16'h09C4, 16'h0040};
   logic [4:0]  intr_phy_reg_a, intr_phy_reg_b, id;
   logic [9:0]  phy_mgmt_id;
   logic [1:0]  phy_present, phy_gigabit, phy_link_forced;
   logic [2:0]  t, ty [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
   logic [63:0] frm, frames[$];
   integer      seed = 61436;
   int          failures = 0, n_compared = 0, nb, r, i, k, w;
   eeprom_config_preloader #(.SER_DIV(2)) dut (.*);
   eeprom_serial_model ee (.*);
   initial begin
      clk_sys = 0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [63:0] s, e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task end_of_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // collect whole management frames at rising mdc
   always @(posedge mdc) if (mdio_oe === 1'b1) begin
      frm = {frm[62:0], mdio_o};
      nb++;
      if (nb == 64) begin frames.push_back(frm); nb = 0; end
   end
   // four loads of about 3500 clocks fit easily
   initial begin #1500000; failures++; end_of_test; end
   initial begin
      {nrst, jumbo_mode, full_duplex, rx_free_blocks, phy_reset_level} = '0;
      {phy_reset_enable_bit, usb_bus_reset} = '0;
      for (r = 0; r < 4; r++) begin
         for (k = 0; k < 256; k++) ee.mem[k] = $random(seed);
         ee.mem[0][7:0] = 8'h15;
         ee.mem[1][5] = r[0];
         ee.mem[16] = fs[r];
         ee.mem[17] = {ty[3-r], ee.mem[17][12:8], ty[r], ee.mem[17][4:0]};
         ee.mem[18] = {ee.mem[18][15:8] & 8'h3F, ee.mem[18][7:0] | 8'h40};
         fsx = fs[r] > 16'h09C4 ? 16'h09C4 : fs[r] & 16'hFFFE;
         @(posedge clk_sys) #5 {nrst, full_duplex, pm} = '0; // pause starts cleared
         ee.addrs.delete(); frames.delete(); nb = 0;
         repeat (8) @(posedge clk_sys);
         #5 nrst = 1;
         for (i = 0; i < 6000 && config_valid !== 1'b1; i++) @(posedge clk_sys);
         #5 chk(config_valid, 1);
         chk(ee.addrs.size(), 21);
         for (k = 0; k < ee.addrs.size(); k++) chk(ee.addrs[k], k);
         chk(ee.bad_hdr, 0);
         chk(preload_count, 8'h15);
         for (k = 0; k < 11; k++) begin
            w = k < 2 ? k + 2 : k < 4 ? k + 17 : k + 4;
            chk(desc_offset[8*k+:8], ee.mem[w][7:0]);
            chk(desc_length[8*k+:8], ee.mem[w][15:8]);
         end
         chk(lang_id, ee.mem[7]);
         chk(mac_addr, {ee.mem[6], ee.mem[5], ee.mem[4]});
         chk({debug_port_enable, capture_effect_enable, tx_crc_append_enable, rx_crc_strip_enable,
            sw_phy_reset_select, chirp_k_disable, remote_wake_capable, self_powered_flag},
            {ee.mem[1][13:12], ee.mem[1][7:4], ee.mem[1][2], ee.mem[1][0]});
         chk({intr_phy_reg_a, intr_phy_reg_b}, {ee.mem[15][12:8], ee.mem[15][4:0]});
         chk(phy_mgmt_id, {ee.mem[17][12:8], ee.mem[17][4:0]});
         for (k = 0; k < 2; k++) begin
            t = k ? ty[3-r] : ty[r];
            chk({phy_present[k], phy_gigabit[k], phy_link_forced[k]},
               {t != 3'h7, t == 3'h1, t == 3'h4});
         end
         chk(frames.size(), 3);
         for (k = 0; k < frames.size(); k++) begin
            id = k ? ee.mem[17][8*k-8+:5] : `PD_BROADCAST_ID;
            chk(frames[k], {`MDIO_PREAMBLE, `MDIO_ST_WR, id, `PD_REG_ADDR, `MDIO_TA,
               `PD_REG_DATA});
         end
         // random live inputs, each result one clock later
         for (i = 0; i < 300; i++) begin
            @(posedge clk_sys) #5;
            if (i > 0) begin
               chk(pause_active, pm);
               chk(max_frame_size, jumbo_mode ? 16'h2400 : fsx);
               chk(phy_reset_out_n, pr);
            end
            {full_duplex, jumbo_mode, phy_reset_level, phy_reset_enable_bit, usb_bus_reset} =
               5'($random(seed));
            rx_free_blocks = 8'($random(seed));
            pm = !full_duplex ? 1'b0 : rx_free_blocks <= ee.mem[18][15:8] ? 1'b1 :
               rx_free_blocks >= ee.mem[18][7:0] ? 1'b0 : pm;
            pr = r[0] ? (phy_reset_enable_bit ? phy_reset_level : 1'b1) :
               !(phy_reset_enable_bit && usb_bus_reset);
         end
         $display("load %0d done", r);
      end
      end_of_test;
   end
endmodule
